// file: include/timer16_pkg.sv
// Package for the 16-bit pulse generator and capture timer.
package timer16_pkg;
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] clksel_addr = 12'h004;
  localparam logic [11:0] period_addr = 12'h008;
  localparam logic [11:0] duty_addr = 12'h00c;
  localparam logic [11:0] count_addr = 12'h010;
  localparam logic [11:0] irq_stat_addr = 12'h014;
  localparam logic [11:0] irq_mask_addr = 12'h018;
  localparam logic [11:0] cap_a_addr = 12'h01c;
  localparam logic [11:0] cap_b_addr = 12'h020;

  localparam logic [1:0] run_stop = 2'h0;
  localparam logic [1:0] run_clear_cap = 2'h1;
  localparam logic [1:0] run_free = 2'h2;
  localparam logic [1:0] run_clear_match = 2'h3;

  localparam logic [1:0] edge_fall = 2'h0;
  localparam logic [1:0] edge_rise = 2'h1;
  localparam logic [1:0] edge_both = 2'h3;

  localparam logic [1:0] cksel_pclk = 2'h0;
  localparam logic [1:0] cksel_div4 = 2'h1;
  localparam logic [1:0] cksel_div16 = 2'h2;
  localparam logic [1:0] cksel_ext = 2'h3;
  localparam logic [3:0] div4_mask = 4'h3;
  localparam logic [3:0] div16_mask = 4'hf;

  localparam int irq_duty_bit = 0;
  localparam int irq_period_bit = 1;
  localparam int irq_cap_a_bit = 2;
  localparam int irq_cap_b_bit = 3;
  localparam int irq_width = 4;

  localparam logic [15:0] period_reset = 16'hffff;
  localparam logic [15:0] duty_reset = 16'h0000;
  localparam logic [31:0] rdata_zero = 32'h0000_0000;

  // Control register layout, high bits first.
  typedef struct packed {
    logic [19:0] unused;
    logic pin_is_output;    // shared pin drives timer_out when set
    logic duty_match_toggle_en;
    logic pulse_train_mode;
    logic [1:0] edge_b;
    logic [1:0] edge_a;
    logic out_active_level;
    logic [1:0] run_mode;   // run_mode_hi, run_mode_lo
    logic [1:0] spare;
  } ctrl_type;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] cap_a;
    logic [15:0] cap_b;
  } timer_state_type;
endpackage : timer16_pkg

// file: test/tb_timer16_pulse_gen_capture.sv
// Self-checking bench for the pulse and capture timer.
`timescale 1ns/100ps
module tb_timer16_pulse_gen_capture;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic a_lvl = 1'b1;
  logic b_lvl = 1'b0;
  logic [31:0] prdata, rd, ca;
  logic pready, pslverr, err, capture_in_a, duty_match_irq;
  logic shared_port_in, shared_port_out, shared_port_oe_n;
  logic [15:0] per, hi, p, d;
  logic [15:0] seed = 16'h41d5;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int w = 0;
  always #4 pclk = ~pclk;
  timer16_pulse_gen_capture DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_in_a(capture_in_a),
    .shared_port_in(shared_port_in), .shared_port_out(shared_port_out),
    .shared_port_oe_n(shared_port_oe_n), .duty_match_irq(duty_match_irq)
  );
  timer16_pin_model pins (
    .pclk(pclk), .a_lvl(a_lvl), .b_lvl(b_lvl), .pin_out(shared_port_out),
    .pin_oe_n(shared_port_oe_n), .capture_in_a(capture_in_a),
    .shared_port_in(shared_port_in), .per_ff(per), .hi_ff(hi)
  );
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] ticks(input logic [15:0] v);
    return {16'h0000, v} + 32'h0000_0001;
  endfunction : ticks
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr
  task automatic measure(input logic [15:0] pv, input logic [15:0] dv,
                         input int m);
    repeat (3 * m * (pv + 1) + 12) @(posedge pclk);
    check({16'h0000, per}, ticks(pv) * m);
    check({16'h0000, hi}, ticks(dv) * m);
    check({31'h0, duty_match_irq}, 32'h1);
  endtask : measure
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, timer16_pkg::period_addr, 32'h0);
    check(rd, 32'hffff);
    apb(1'b0, timer16_pkg::irq_mask_addr, 32'h0);
    check(rd, 32'hf);
    apb(1'b0, 12'h024, 32'h0);
    check({err, rd[30:0]}, 32'h8000_0000);
    // Pin a is high from reset, so the first run sees a rising edge.
    wr(timer16_pkg::ctrl_addr, 32'h28);
    repeat (8) @(posedge pclk);
    apb(1'b0, timer16_pkg::irq_stat_addr, 32'h0);
    check({31'h0, rd[3]}, 32'h1);
    apb(1'b0, timer16_pkg::count_addr, 32'h0);
    check({31'h0, |rd[15:0]}, 32'h1);
    wr(timer16_pkg::ctrl_addr, 32'h20);
    wr(timer16_pkg::irq_stat_addr, 32'hf);
    wr(timer16_pkg::ctrl_addr, 32'h28);
    repeat (8) @(posedge pclk);
    apb(1'b0, timer16_pkg::irq_stat_addr, 32'h0);
    check({31'h0, rd[3]}, 32'h0);
    wr(timer16_pkg::ctrl_addr, 32'h0);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      p = {11'h000, seed[4:0]} + 16'h0004;
      seed = lfsr(seed);
      d = (i == 0) ? 16'h0000 : {8'h00, seed[7:0]} % p;
      wr(timer16_pkg::period_addr, {16'h0000, p});
      wr(timer16_pkg::duty_addr, {16'h0000, d});
      wr(timer16_pkg::irq_stat_addr, 32'hf);
      wr(timer16_pkg::irq_mask_addr, 32'he);
      wr(timer16_pkg::ctrl_addr, 32'hf5c);
      measure(p, d, 1);
      wr(timer16_pkg::ctrl_addr, 32'hb5c);
      wr(timer16_pkg::irq_mask_addr, 32'hf);
      repeat (2) @(posedge pclk);
      check({31'h0, duty_match_irq}, 32'h0);
      d = (d + 16'h0001) % (p - 16'h0001);
      wr(timer16_pkg::duty_addr, {16'h0000, d});
      @(posedge pclk);
      wr(timer16_pkg::ctrl_addr, 32'hf5c);
      wr(timer16_pkg::irq_stat_addr, 32'h1);
      wr(timer16_pkg::irq_mask_addr, 32'he);
      measure(p, d, 1);
      wr(timer16_pkg::ctrl_addr, 32'h0);
    end
    // Width measurement: a rise on pin a opens it, a fall on the shared
    // pin closes it; both pins are capture inputs here.
    a_lvl <= 1'b0;
    b_lvl <= 1'b1;
    repeat (6) @(posedge pclk);
    wr(timer16_pkg::ctrl_addr, 32'h28);
    seed = lfsr(seed);
    w = {28'h0, seed[3:0]} + 8;
    repeat (4) @(posedge pclk);
    a_lvl <= 1'b1;
    repeat (w) @(posedge pclk);
    b_lvl <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, timer16_pkg::cap_a_addr, 32'h0);
    ca = rd;
    apb(1'b0, timer16_pkg::cap_b_addr, 32'h0);
    check(ca - rd, w);
    wr(timer16_pkg::ctrl_addr, 32'h0);
    // Codes 1 and 2 divide the count clock by 4 and by 16.
    for (int j = 1; j < 3; j++) begin
      wr(timer16_pkg::clksel_addr, 32'(j));
      wr(timer16_pkg::ctrl_addr, 32'hf5c);
      measure(p, d, 1 << (2 * j));
      wr(timer16_pkg::ctrl_addr, 32'h0);
    end
    // Filtered rising edges of pin a serve as the count clock.
    a_lvl <= 1'b0;
    repeat (6) @(posedge pclk);
    wr(timer16_pkg::clksel_addr, 32'h3);
    wr(timer16_pkg::ctrl_addr, 32'h8);
    seed = lfsr(seed);
    w = {28'h0, seed[3:0]} + 1;
    repeat (w) begin
      a_lvl <= 1'b1;
      repeat (4) @(posedge pclk);
      a_lvl <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (6) @(posedge pclk);
    apb(1'b0, timer16_pkg::count_addr, 32'h0);
    check(rd, w);
    complete_run();
  end
endmodule : tb_timer16_pulse_gen_capture

// file: test/timer16_pin_model.sv
// Pin-side partner: drives the capture pins and times the output pulse.
`timescale 1ns/100ps
module timer16_pin_model (
  input wire logic pclk, // clock
  input wire logic a_lvl, // level offered on pin a
  input wire logic b_lvl, // level offered on the shared pin
  input wire logic pin_out, // device drive of the shared pin
  input wire logic pin_oe_n, // low while the device drives
  output logic capture_in_a, // pin a level
  output logic shared_port_in, // resolved shared pin level
  output logic [15:0] per_ff, // cycles between rising edges
  output logic [15:0] hi_ff // high cycles in the last period
);
  logic [15:0] cnt_ff = 16'h0000;
  logic [15:0] hcnt_ff = 16'h0000;
  logic last_ff = 1'b1;
  assign capture_in_a = a_lvl;
  assign shared_port_in = pin_oe_n ? b_lvl : pin_out;
  always @(posedge pclk) begin
    last_ff <= shared_port_in;
    if (shared_port_in && !last_ff) begin
      per_ff <= cnt_ff + 16'h0001;
      hi_ff <= hcnt_ff;
      cnt_ff <= 16'h0000;
      hcnt_ff <= 16'h0001;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
      hcnt_ff <= hcnt_ff + {15'h0000, shared_port_in};
    end
  end
endmodule : timer16_pin_model

// file: test/timer16_pulse_gen_capture_monitor.sv
// Port checker for the pulse and capture timer.
`timescale 1ns/100ps
module timer16_pulse_gen_capture_monitor #(
  parameter int cnt_width = 16 // counter width
) (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic shared_port_oe_n, // pin enable
  input wire logic duty_match_irq // interrupt
);
  logic acc;
  logic ctrl_wr;
  logic irq_wr;
  assign acc = psel && penable;
  assign ctrl_wr = acc && pwrite && paddr == timer16_pkg::ctrl_addr;
  assign irq_wr = acc && pwrite && (paddr == timer16_pkg::irq_stat_addr
    || paddr == timer16_pkg::irq_mask_addr);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (acc |-> pready)
    else $error("access without ready");
  a_err_decode: assert property (acc |-> pslverr == (paddr[1:0] != 2'h0
    || paddr > timer16_pkg::cap_b_addr)) else $error("bad error decode");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  a_err_read_zero: assert property (acc && !pwrite && pslverr
    |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  a_pin_dir_cause: assert property ($changed(shared_port_oe_n)
    |-> $past(ctrl_wr) || $past(ctrl_wr, 2)) else $error("pin role moved");
  a_irq_fall_cause: assert property ($fell(duty_match_irq)
    |-> $past(irq_wr) || $past(irq_wr, 2)) else $error("irq fell alone");
  a_irq_mask_all: assert property (irq_wr && &pwdata[3:0]
    && paddr == timer16_pkg::irq_mask_addr |=> ##1 !duty_match_irq)
    else $error("masked irq still high");
endmodule : timer16_pulse_gen_capture_monitor
bind timer16_pulse_gen_capture timer16_pulse_gen_capture_monitor #(
  .cnt_width(cnt_width)
) mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .shared_port_oe_n(shared_port_oe_n),
  .duty_match_irq(duty_match_irq)
);

// file: verilog/timer16_pulse_gen_capture.sv
// Sixteen-bit timer with prescaler, compare, capture and pulse output.
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/100ps
module timer16_pulse_gen_capture #(
  parameter int cnt_width = 16      // counter width
) (
  input wire logic pclk,            // APB clock, 125 MHz
  input wire logic presetn,         // asynchronous reset, active low
  input wire logic psel,            // APB select
  input wire logic penable,         // APB access phase
  input wire logic pwrite,          // APB direction
  input wire logic [11:0] paddr,    // APB byte address
  input wire logic [31:0] pwdata,   // APB write data
  output logic [31:0] prdata,       // APB read data
  output logic pready,              // APB ready, always high
  output logic pslverr,             // APB error on unmapped address
  input wire logic capture_in_a,    // capture or event input pin
  input wire logic shared_port_in,  // shared pin level, capture b
  output logic shared_port_out,     // shared pin drive, timer_out
  output logic shared_port_oe_n,    // shared pin enable, low drives
  output logic duty_match_irq       // interrupt, active high level
);
  timer16_pkg::ctrl_type ctrl_ff;
  logic [1:0] clksel_ff;
  logic [cnt_width-1:0] period_compare_ff;
  logic [cnt_width-1:0] duty_compare_ff;
  logic [timer16_pkg::irq_width-1:0] duty_irq_flag_ff;
  logic [timer16_pkg::irq_width-1:0] duty_irq_mask_ff;
  timer16_pkg::timer_state_type st_ff;
  logic timer_out_ff;
  logic [31:0] prdata_ff;
  logic [1:0] sync_a_ff, sync_b_ff;
  logic a_prev_ff, b_prev_ff;
  logic [3:0] pre_ff;
  logic ext_filt_ff;
  logic ext_prev_ff;
  logic fresh_ff;

  wire logic wr_en = psel & penable & pwrite;
  wire logic rd_en = psel & ~penable & ~pwrite;
  wire logic running = ctrl_ff.run_mode != timer16_pkg::run_stop;
  logic mapped;
  logic tick;
  logic [timer16_pkg::irq_width-1:0] events;
  logic rise_a, fall_a, rise_b, fall_b, valid_a, valid_b;
  logic a_lvl, b_lvl;
  logic period_match, duty_match;
  logic [cnt_width-1:0] nxt_count;

  // Only the nine word addresses answer; anything else raises the error
  // response and reads as zero.
  always_comb begin
    case (paddr)
      timer16_pkg::ctrl_addr, timer16_pkg::clksel_addr,
      timer16_pkg::period_addr, timer16_pkg::duty_addr,
      timer16_pkg::count_addr, timer16_pkg::irq_stat_addr,
      timer16_pkg::irq_mask_addr, timer16_pkg::cap_a_addr,
      timer16_pkg::cap_b_addr: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_ff;

  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_ff <= 2'h0;
      sync_b_ff <= 2'h0;
    end else begin
      sync_a_ff <= {sync_a_ff[0], capture_in_a};
      sync_b_ff <= {sync_b_ff[0], shared_port_in};
    end
  end
  assign a_lvl = sync_a_ff[1];
  assign b_lvl = sync_b_ff[1] & ~ctrl_ff.pin_is_output;

  // Edge history; zero after reset so a high pin shows a rising edge,
  // but on a restart it is loaded with the present level.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_prev_ff <= 1'b0;
      b_prev_ff <= 1'b0;
      fresh_ff <= 1'b1;
    end else begin
      if (running) begin
        fresh_ff <= 1'b0;
      end
      if (!running && !fresh_ff) begin
        a_prev_ff <= a_lvl;
        b_prev_ff <= b_lvl;
      end else if (running) begin
        a_prev_ff <= a_lvl;
        b_prev_ff <= b_lvl;
      end
    end
  end
  assign rise_a = a_lvl & ~a_prev_ff & running;
  assign fall_a = ~a_lvl & a_prev_ff & running;
  assign rise_b = b_lvl & ~b_prev_ff & running;
  assign fall_b = ~b_lvl & b_prev_ff & running;

  // Picks the valid edge of one capture input; code 2 selects no edge.
  function automatic logic edge_sel(input logic [1:0] sel, input logic r,
                                    input logic f);
    case (sel)
      timer16_pkg::edge_fall: edge_sel = f;
      timer16_pkg::edge_rise: edge_sel = r;
      timer16_pkg::edge_both: edge_sel = r | f;
      default: edge_sel = 1'b0;
    endcase
  endfunction : edge_sel

  assign valid_a = edge_sel(ctrl_ff.edge_a, rise_a, fall_a);
  assign valid_b = edge_sel(ctrl_ff.edge_b, rise_b, fall_b);

  // External count clock is filtered: it must hold two samples.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_filt_ff <= 1'b0;
      ext_prev_ff <= 1'b0;
    end else begin
      if (a_lvl == a_prev_ff) begin
        ext_filt_ff <= a_lvl;
      end
      ext_prev_ff <= ext_filt_ff;
    end
  end

  // The prescaler runs only while counting, so every start begins a fresh
  // divided period and the first tick comes one full division late.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_ff <= 4'h0;
    end else if (!running) begin
      pre_ff <= 4'h0;
    end else begin
      pre_ff <= pre_ff + 4'h1;
    end
  end

  // One-cycle count enable; the counter never sees a second clock.
  always_comb begin
    case (clksel_ff)
      timer16_pkg::cksel_pclk: tick = running;
      timer16_pkg::cksel_div4:
        tick = running & ((pre_ff & timer16_pkg::div4_mask) ==
                          timer16_pkg::div4_mask);
      timer16_pkg::cksel_div16:
        tick = running & (pre_ff == timer16_pkg::div16_mask);
      timer16_pkg::cksel_ext: tick = running & ext_filt_ff & ~ext_prev_ff;
      default: tick = 1'b0;
    endcase
  end

  // Matches are taken only on a tick, so a slow count clock raises each
  // match for one cycle and not for a whole count period.
  assign period_match = tick && st_ff.count == period_compare_ff;
  assign duty_match = tick && st_ff.count == duty_compare_ff;

  // Counter: capture-clear, free run, or clear on period match.
  always_comb begin
    nxt_count = st_ff.count;
    if (!running) begin
      nxt_count = '0;
    end else if (ctrl_ff.run_mode == timer16_pkg::run_clear_cap &&
                 valid_a) begin
      nxt_count = '0;
    end else if (tick) begin
      if ((ctrl_ff.run_mode == timer16_pkg::run_clear_match ||
           ctrl_ff.pulse_train_mode) && period_match) begin
        nxt_count = '0;
      end else begin
        nxt_count = st_ff.count + 1'b1;
      end
    end
  end

  // Input b latches into capture a and input a into capture b; the
  // period-clear mode leaves capture b alone.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff.count <= nxt_count;
      if (valid_b) begin
        st_ff.cap_a <= st_ff.count;
      end
      if (valid_a && ctrl_ff.run_mode != timer16_pkg::run_clear_match) begin
        st_ff.cap_b <= st_ff.count;
      end
    end
  end

  // Output: active level at period start, toggle at duty match.
  // Stopping parks it at the inactive level, so the first period after
  // a start shows a stretched active phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_out_ff <= 1'b0;
    end else if (!running) begin
      timer_out_ff <= ~ctrl_ff.out_active_level;
    end else if (ctrl_ff.pulse_train_mode && period_match) begin
      timer_out_ff <= ctrl_ff.out_active_level;
    end else if (ctrl_ff.duty_match_toggle_en && duty_match) begin
      timer_out_ff <= ~timer_out_ff;
    end
  end
  assign shared_port_out = timer_out_ff;
  assign shared_port_oe_n = ~ctrl_ff.pin_is_output;

  // Event vector, one bit for each status flag.
  always_comb begin
    events = '0;
    events[timer16_pkg::irq_duty_bit] = duty_match;
    events[timer16_pkg::irq_period_bit] = period_match;
    events[timer16_pkg::irq_cap_a_bit] = valid_b;
    events[timer16_pkg::irq_cap_b_bit] = valid_a;
  end

  // Register writes; a new event wins over a write-one clear.
  // The count and both capture registers are read only; writes to them
  // are accepted and dropped.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= '0;
      clksel_ff <= timer16_pkg::cksel_pclk;
      period_compare_ff <= timer16_pkg::period_reset;
      duty_compare_ff <= timer16_pkg::duty_reset;
      // Every source starts masked.
      duty_irq_mask_ff <= '1;
      duty_irq_flag_ff <= '0;
    end else begin
      if (wr_en && paddr == timer16_pkg::ctrl_addr) begin
        ctrl_ff <= timer16_pkg::ctrl_type'(pwdata);
      end
      if (wr_en && paddr == timer16_pkg::clksel_addr) begin
        clksel_ff <= pwdata[1:0];
      end
      if (wr_en && paddr == timer16_pkg::period_addr) begin
        period_compare_ff <= pwdata[cnt_width-1:0];
      end
      if (wr_en && paddr == timer16_pkg::duty_addr) begin
        duty_compare_ff <= pwdata[cnt_width-1:0];
      end
      if (wr_en && paddr == timer16_pkg::irq_mask_addr) begin
        duty_irq_mask_ff <= pwdata[timer16_pkg::irq_width-1:0];
      end
      if (wr_en && paddr == timer16_pkg::irq_stat_addr) begin
        duty_irq_flag_ff <= (duty_irq_flag_ff &
                             ~pwdata[timer16_pkg::irq_width-1:0]) | events;
      end else begin
        duty_irq_flag_ff <= duty_irq_flag_ff | events;
      end
    end
  end

  // The interrupt is a level, up while any unmasked flag is set.
  assign duty_match_irq = |(duty_irq_flag_ff &
                            ~duty_irq_mask_ff);

  // Read data is loaded in the setup cycle, so it stands for the whole
  // access phase and no wait state is needed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= timer16_pkg::rdata_zero;
    end else if (rd_en) begin
      case (paddr)
        timer16_pkg::ctrl_addr: prdata_ff <= 32'(ctrl_ff);
        timer16_pkg::clksel_addr: prdata_ff <= 32'(clksel_ff);
        timer16_pkg::period_addr: prdata_ff <= 32'(period_compare_ff);
        timer16_pkg::duty_addr: prdata_ff <= 32'(duty_compare_ff);
        timer16_pkg::count_addr: prdata_ff <= 32'(st_ff.count);
        timer16_pkg::irq_stat_addr: prdata_ff <= 32'(duty_irq_flag_ff);
        timer16_pkg::irq_mask_addr: prdata_ff <= 32'(duty_irq_mask_ff);
        timer16_pkg::cap_a_addr: prdata_ff <= 32'(st_ff.cap_a);
        timer16_pkg::cap_b_addr: prdata_ff <= 32'(st_ff.cap_b);
        default: prdata_ff <= timer16_pkg::rdata_zero;
      endcase
    end
  end
endmodule : timer16_pulse_gen_capture
